//--- tim_pkg.sv
/*
   Constants shared by the temperature interrupt mask and mode block.
   Assumes it is compiled before every other file of the block.
*/
`default_nettype none

package tim_pkg;

   // Width of the second interrupt mask register
   localparam int unsigned TIM_REG_W = 8;

   // Power-on value of the second interrupt mask register
   localparam logic [7:0] TIM_MASK2_RESET = 8'h00;

   // Field positions inside the second interrupt mask register
   localparam int unsigned TIM_BIT_FAN_ONE = 2;
   localparam int unsigned TIM_BIT_FAN_TWO = 3;
   localparam int unsigned TIM_BIT_CHASSIS = 4;
   localparam int unsigned TIM_BIT_OVERTEMP = 5;
   localparam int unsigned TIM_BIT_HOT_MODE = 6;
   localparam int unsigned TIM_BIT_OT_MODE = 7;

   // Lowest mask bit held by this block; bits below it read as zero
   localparam int unsigned TIM_BIT_LOW = 2;

   // Number of temperature events and masked sources
   localparam int unsigned TIM_NUM_TEMP = 2;
   localparam int unsigned TIM_NUM_SRC = 4;

   // Index of each temperature event in the event vectors
   localparam int unsigned TIM_EVT_HOT = 0;
   localparam int unsigned TIM_EVT_OT = 1;

   // Interrupt mode of a temperature event
   typedef enum logic
   {
      TIM_MODE_DEFAULT,
      TIM_MODE_ONE_TIME
   } tim_mode_e;

endpackage : tim_pkg

`default_nettype wire

//--- tim_evt_if.sv
/*
   Carrier between the mask/mode top and one temperature event tracker.
   Assumes one instance per temperature event, all on the device clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface tim_evt_if;
   import tim_pkg::*;

   logic conv_done;
   logic above_hot;
   logic below_hyst;
   logic status_read;
   tim_mode_e mode;
   logic flag;

   // Top side: feeds comparisons and mode, reads the status flag
   modport ctrl
   (
      output conv_done,
      output above_hot,
      output below_hyst,
      output status_read,
      output mode,
      input flag
   );

   // Tracker side
   modport track
   (
      input conv_done,
      input above_hot,
      input below_hyst,
      input status_read,
      input mode,
      output flag
   );

endinterface : tim_evt_if

`default_nettype wire

//--- tim_evt_track.sv
/*
   One temperature event tracker: keeps the sticky status flag of a
   hot-limit / hysteresis comparison in default or one-time mode.
   Assumes comparison levels are valid in the cycle of conv_done.
*/
`timescale 1ns/1ps
`default_nettype none

module tim_evt_track
   import tim_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   tim_evt_if.track evt
);

   logic over_q;
   logic set_d;

   // Raise decision, only evaluated on a finished conversion
   always_comb
   begin
      set_d = 1'b0;
      if (evt.conv_done)
      begin
         case (evt.mode)
            TIM_MODE_DEFAULT:
               // Repeat while hot or still above hysteresis
               set_d = evt.above_hot || (over_q && !evt.below_hyst);
            TIM_MODE_ONE_TIME:
               // Only on a crossing in either direction
               set_d = (!over_q && evt.above_hot) || (over_q && evt.below_hyst);
            default:
               set_d = 1'b0;
         endcase
      end
   end

   // Over-limit state, left only by falling below hysteresis
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
         over_q <= 1'b0;
      else if (evt.conv_done && evt.above_hot)
         over_q <= 1'b1;
      else if (evt.conv_done && evt.below_hyst)
         over_q <= 1'b0;
   end

   // Sticky flag: a status read clears it, a same-cycle set wins
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
         evt.flag <= 1'b0;
      else if (set_d)
         evt.flag <= 1'b1;
      else if (evt.status_read)
         evt.flag <= 1'b0;
   end

endmodule : tim_evt_track

`default_nettype wire

//--- tim_mask_mode.sv
/*
   Upper six bits of the second interrupt mask register: four mask bits
   for fan, chassis and overtemperature status, and two mode bits for the
   hot-temperature and overtemperature events, with their event trackers.
   Assumes the serial register bus logic outside delivers a write strobe
   with data for this register and a one-cycle strobe for each status
   register read; fan and chassis flags come from the status register.
*/
//
// Operation
// - Bits 2-5 mask fan, chassis, overtemp interrupts
// - Bits 6/7 pick hot/overtemp mode, 1=one-time
// - Default mode interrupts while above hot limit
// - Status read clears pending temperature interrupt
// - Default mode re-raises at next conversion
// - Default repeats until below hysteresis limit
// - One-time raises once on crossing hot limit
// - One-time next raises on dropping below hysteresis
// - Then silent until above hot again
// - One-time bit holds across status reads
// - All register bits zero after reset
// - Hot status bit follows bit-6 mode
`timescale 1ns/1ps
`default_nettype none

module tim_mask_mode
   import tim_pkg::*;
#(
   parameter int unsigned NUM_TEMP = TIM_NUM_TEMP
)
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic mask_wr_in,
   input wire logic [TIM_REG_W-1:0] mask_wdata_in,
   output logic [TIM_REG_W-1:0] mask_rdata_out,
   input wire logic status_read_in,
   input wire logic [NUM_TEMP-1:0] conv_done_in,
   input wire logic [NUM_TEMP-1:0] above_hot_in,
   input wire logic [NUM_TEMP-1:0] below_hyst_in,
   input wire logic fan_one_limit_in,
   input wire logic fan_two_limit_in,
   input wire logic chassis_intrusion_in,
   output logic hot_status_out,
   output logic overtemp_shutdown_event_out,
   output logic [TIM_NUM_SRC-1:0] src_pending_out,
   output logic int_req_out
);

   // Held register bits 7..2
   logic [TIM_REG_W-1:TIM_BIT_LOW] mask_q;
   logic [TIM_NUM_SRC-1:0] src_raw;
   logic [TIM_NUM_SRC-1:0] src_gated;
   logic [NUM_TEMP-1:0] temp_flag;
   tim_mode_e mode_sel [NUM_TEMP];

   // Gates one status bit by its mask bit; mask set means no interrupt
   function automatic logic tim_gate(input logic status, input logic mask);
      tim_gate = status && !mask;
   endfunction : tim_gate

   // Decodes a mode bit into the mode enumeration
   function automatic tim_mode_e tim_mode(input logic sel);
      tim_mode = sel ? TIM_MODE_ONE_TIME : TIM_MODE_DEFAULT;
   endfunction : tim_mode

   // Register write; bits 1..0 belong elsewhere and are dropped here
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
         mask_q <= TIM_MASK2_RESET[TIM_REG_W-1:TIM_BIT_LOW];
      else if (mask_wr_in)
         mask_q <= mask_wdata_in[TIM_REG_W-1:TIM_BIT_LOW];
   end

   // Read-back from a flop so the bus sees a stable byte
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
         mask_rdata_out <= TIM_MASK2_RESET;
      else
         mask_rdata_out <= {mask_q, {TIM_BIT_LOW{1'b0}}};
   end

   // Mode of each temperature event from bits 6 and 7
   always_comb
   begin
      mode_sel[TIM_EVT_HOT] = tim_mode(mask_q[TIM_BIT_HOT_MODE]);
      mode_sel[TIM_EVT_OT] = tim_mode(mask_q[TIM_BIT_OT_MODE]);
   end

   // One tracker per temperature event
   generate
      for (genvar i = 0; i < NUM_TEMP; i++)
      begin : g_temp
         tim_evt_if evt_bus ();

         // Feed comparisons, the mode and the status read strobe
         assign evt_bus.conv_done = conv_done_in[i];
         assign evt_bus.above_hot = above_hot_in[i];
         assign evt_bus.below_hyst = below_hyst_in[i];
         assign evt_bus.status_read = status_read_in;
         assign evt_bus.mode = mode_sel[i];
         assign temp_flag[i] = evt_bus.flag;

         tim_evt_track u_track
         (
            .clk_sys_in(clk_sys_in),
            .reset_n_in(reset_n_in),
            .evt(evt_bus.track)
         );
      end
   endgenerate

   // Raw status in mask-bit order: fan one, fan two, chassis, overtemp
   assign src_raw = {temp_flag[TIM_EVT_OT], chassis_intrusion_in,
                     fan_two_limit_in, fan_one_limit_in};

   // Mask gating of the four sources; status itself is never masked
   generate
      for (genvar s = 0; s < TIM_NUM_SRC; s++)
      begin : g_src
         assign src_gated[s] = tim_gate(src_raw[s], mask_q[TIM_BIT_FAN_ONE + s]);
      end
   endgenerate

   // Status outputs are the raw flags, whatever the mask says
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         hot_status_out <= 1'b0;
         overtemp_shutdown_event_out <= 1'b0;
      end
      else
      begin
         hot_status_out <= temp_flag[TIM_EVT_HOT];
         overtemp_shutdown_event_out <= temp_flag[TIM_EVT_OT];
      end
   end

   // Gated contributions and their OR; one flop of delay keeps it glitch free
   always_ff @(posedge clk_sys_in)
   begin
      if (!reset_n_in)
      begin
         src_pending_out <= '0;
         int_req_out <= 1'b0;
      end
      else
      begin
         src_pending_out <= src_gated;
         int_req_out <= |src_gated;
      end
   end

endmodule : tim_mask_mode

`default_nettype wire

//--- tim_mask_mode_monitor.sv
/*
   Port checker for the mask/mode block.
   Assumes it is bound into tim_mask_mode on the device clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tim_mask_mode_monitor
   import tim_pkg::*;
#(
   parameter int unsigned NUM_TEMP = TIM_NUM_TEMP
)
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic mask_wr_in,
   input wire logic [TIM_REG_W-1:0] mask_wdata_in,
   input wire logic [TIM_REG_W-1:0] mask_rdata_out,
   input wire logic status_read_in,
   input wire logic [NUM_TEMP-1:0] conv_done_in,
   input wire logic [NUM_TEMP-1:0] above_hot_in,
   input wire logic fan_one_limit_in,
   input wire logic hot_status_out,
   input wire logic overtemp_shutdown_event_out,
   input wire logic [TIM_NUM_SRC-1:0] src_pending_out,
   input wire logic int_req_out
);
   // One domain; checks sleep while reset is low
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (!reset_n_in);
   chk_int_or:
      assert property (int_req_out == |src_pending_out) else $error("int not OR of pending");
   chk_fan_gate:
      assert property ($past(reset_n_in) |-> src_pending_out[0] ==
         ($past(fan_one_limit_in) && !mask_rdata_out[2])) else $error("fan gating wrong");
   chk_ot_gate:
      assert property (src_pending_out[3] == (overtemp_shutdown_event_out
         && !mask_rdata_out[5])) else $error("overtemp gating wrong");
   chk_low_bits:
      assert property (mask_rdata_out[1:0] == 2'h0) else $error("low mask bits set");
   chk_read_back:
      assert property (mask_wr_in |-> ##2 mask_rdata_out[7:2] == $past(mask_wdata_in[7:2], 2))
         else $error("mask read-back wrong");
   chk_read_clear:
      assert property (status_read_in && !conv_done_in[0] |-> ##2 !hot_status_out)
         else $error("hot flag survived read");
   chk_rise_conv:
      assert property ($rose(hot_status_out) |-> $past(conv_done_in[0], 2))
         else $error("hot flag rose without conversion");
   chk_dflt_set:
      assert property (conv_done_in[0] && above_hot_in[0] && !mask_rdata_out[6]
         && !$past(mask_wr_in) |-> ##2 hot_status_out) else $error("default mode missed");
endmodule : tim_mask_mode_monitor
bind tim_mask_mode tim_mask_mode_monitor #(.NUM_TEMP(NUM_TEMP)) mon_u (.clk_sys_in,
   .reset_n_in, .mask_wr_in, .mask_wdata_in, .mask_rdata_out, .status_read_in,
   .conv_done_in, .above_hot_in, .fan_one_limit_in, .hot_status_out,
   .overtemp_shutdown_event_out, .src_pending_out, .int_req_out);
`default_nettype wire

//--- tim_mask_mode_test.sv
/*
   Self-checking bench with a cycle model of the mask/mode block.
   Assumes inputs driven at the falling edge, outputs settled there.
*/
`timescale 1ns/1ps
`default_nettype none
module tim_mask_mode_test;
   logic clk_sys_in = 1'b0, reset_n_in = 1'b0, mask_wr_in = 1'b0, status_read_in = 1'b0;
   logic fan_one_limit_in = 1'b0, fan_two_limit_in = 1'b0, chassis_intrusion_in = 1'b0;
   logic [1:0] conv_done_in = 2'h0, above_hot_in = 2'h0, below_hyst_in = 2'h0;
   logic [7:0] mask_wdata_in = 8'h00, mask_rdata_out, msk_m, rd_m;
   logic [1:0] flg_m, ovr_m, sts_m;
   logic [3:0] src_pending_out, pnd_m;
   logic hot_status_out, overtemp_shutdown_event_out, int_req_out, int_m, chk_on = 1'b0;
   int err_total = 0, n_compared = 0, cyc = 0;
   logic [3:0] seq [14] = '{4'hC, 4'h0, 4'h1, 4'h8, 4'h1, 4'hC, 4'hB, 4'h1, 4'h8, 4'hA,
      4'hE, 4'h1, 4'h0, 4'h0};
   wire [3:0] pnd_d = {flg_m[1], chassis_intrusion_in, fan_two_limit_in, fan_one_limit_in}
      & ~msk_m[5:2];
   tim_mask_mode #(.NUM_TEMP(2)) dut_u (.clk_sys_in, .reset_n_in, .mask_wr_in,
      .mask_wdata_in, .mask_rdata_out, .status_read_in, .conv_done_in, .above_hot_in,
      .below_hyst_in, .fan_one_limit_in, .fan_two_limit_in, .chassis_intrusion_in,
      .hot_status_out, .overtemp_shutdown_event_out, .src_pending_out, .int_req_out);
   always #5 clk_sys_in = ~clk_sys_in;
   // Flag set term per mode; one-time only fires on a crossing
   function automatic logic set_f(input logic m, o, a, b);
      return m ? ((!o && a) || (o && b)) : (a || (o && !b));
   endfunction : set_f
   // Cycle model: register, trackers, registered gating
   always @(posedge clk_sys_in)
   begin
      cyc <= cyc + 1;
      if (!reset_n_in)
         {msk_m, rd_m, flg_m, ovr_m, sts_m, pnd_m, int_m} <= '0;
      else
      begin
         if (mask_wr_in)
            msk_m <= mask_wdata_in;
         rd_m <= {msk_m[7:2], 2'h0};
         for (int i = 0; i < 2; i++)
         begin
            if (conv_done_in[i])
               ovr_m[i] <= above_hot_in[i] | (ovr_m[i] & ~below_hyst_in[i]);
            flg_m[i] <= (conv_done_in[i] && set_f(msk_m[6+i], ovr_m[i], above_hot_in[i],
               below_hyst_in[i])) || (flg_m[i] && !status_read_in);
         end
         sts_m <= flg_m;
         pnd_m <= pnd_d;
         int_m <= |pnd_d;
      end
   end
   task automatic cmp(input logic [7:0] got, exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test
   // Every output checked each cycle; a hang counts as a fault
   always @(negedge clk_sys_in)
      if (chk_on)
      begin
         cmp(mask_rdata_out, rd_m, "mask");
         cmp({7'h0, hot_status_out}, {7'h0, sts_m[0]}, "hot");
         cmp({7'h0, overtemp_shutdown_event_out}, {7'h0, sts_m[1]}, "ot");
         cmp({4'h0, src_pending_out}, {4'h0, pnd_m}, "pend");
         cmp({7'h0, int_req_out}, {7'h0, int_m}, "int");
         if (cyc == 4000)
         begin
            err_total++;
            finish_test();
         end
      end
   task automatic step(input logic [1:0] cv, ab, bl, input logic rd);
      @(negedge clk_sys_in);
      {conv_done_in, above_hot_in, below_hyst_in} = {cv, ab, bl};
      {status_read_in, mask_wr_in} = {rd, 1'b0};
   endtask : step
   task automatic wr(input logic [7:0] d);
      @(negedge clk_sys_in);
      {conv_done_in, status_read_in, mask_wr_in, mask_wdata_in} = {2'h0, 1'b0, 1'b1, d};
   endtask : wr
   initial
   begin
      void'($urandom(24164));
      repeat (4) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      reset_n_in = 1'b1;
      chk_on <= 1'b1;
      @(negedge clk_sys_in);
      cmp(mask_rdata_out, 8'h00, "reset");
      $display("test reset done");
      // Same crossing walk under each mode pair
      for (int m = 0; m < 4; m++)
      begin
         wr({2'(m), 6'h00});
         foreach (seq[j])
            step({2{seq[j][3]}}, {2{seq[j][2]}}, {2{seq[j][1]}}, seq[j][0]);
         $display("test modes %0d done", m);
      end
      for (int k = 0; k < 1500; k++)
      begin
         if ($urandom_range(15) == 0)
            wr(8'($urandom));
         else
            step(2'($urandom), 2'($urandom), 2'($urandom), $urandom_range(3) == 0);
         {fan_one_limit_in, fan_two_limit_in, chassis_intrusion_in} = 3'($urandom);
      end
      $display("test random done");
      // Mid-run reset after a register write and an above-hot conversion on both events must clear all
      wr(8'hFC);
      step(2'h3, 2'h3, 2'h0, 1'b0);
      @(negedge clk_sys_in);
      {conv_done_in, reset_n_in} = {2'h0, 1'b0};
      repeat (2) @(negedge clk_sys_in);
      reset_n_in = 1'b1;
      @(negedge clk_sys_in);
      cmp(mask_rdata_out, 8'h00, "rerun mask");
      cmp({7'h0, hot_status_out}, 8'h00, "rerun hot");
      $display("test mid reset done");
      step(2'h0, 2'h0, 2'h0, 1'b0);
      finish_test();
   end
endmodule : tim_mask_mode_test
`default_nettype wire
